// ---- core/adc_channel_select.sv ----
// Channel selection and sweep sequencing for the 10-bit converter
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "adc_chsel_defs.svh"
module adc_channel_select (
    input wire logic clk,
    input wire logic sys_rst,
    input wire adc_chsel_pkg::reg_addr_t bus_addr,
    input wire adc_chsel_pkg::reg_data_t bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output adc_chsel_pkg::reg_data_t bus_rdata,
    output logic [3:0] source_select,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    output logic busy,
    output logic [3:0] slot_index,
    output logic [9:0] slot_result,
    output logic slot_write
);
    import adc_chsel_pkg::*;

    logic sweep_reg;
    logic [1:0] len_reg;
    logic [3:0] sel_reg;
    sweep_state_t state_reg;
    channel_t chan_reg;
    logic [3:0] slot_reg;
    logic [3:0] slot_total;
    logic [3:0] select_next;
    logic valid_sel;
    logic start_req;
    logic start_sweep;
    logic [5:0] wait_cnt;
    reg_data_t rdata_next;

    // Write decode; the start bit is a software trigger only
    assign start_req = bus_write && bus_addr == `CHSEL_OFF_MODE_ZERO && bus_wdata[`CHSEL_BIT_START];
    assign valid_sel = sel_reg <= `CHSEL_LAST_CHANNEL;
    // Mode of the start write itself; the stored sweep bit only follows one edge later
    assign start_sweep = bus_wdata[`CHSEL_BIT_SWEEP];

    always_comb begin
        case (len_reg)
            2'b00: slot_total = `CHSEL_SLOTS_LEN0;
            2'b01: slot_total = `CHSEL_SLOTS_LEN1;
            2'b10: slot_total = `CHSEL_SLOTS_LEN2;
            default: slot_total = 4'h0; // Reserved length: a sweep start is refused, a fixed run still converts once
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sweep_reg <= 1'b0;
            len_reg <= 2'b00;
            sel_reg <= 4'h0;
        end else if (bus_write && state_reg == ST_IDLE) begin
            if (bus_addr == `CHSEL_OFF_MODE_ZERO)
                sweep_reg <= bus_wdata[`CHSEL_BIT_SWEEP];
            if (bus_addr == `CHSEL_OFF_MODE_ONE) begin
                sel_reg <= bus_wdata[`CHSEL_SEL_LSB +: 4];
                len_reg <= bus_wdata[`CHSEL_LEN_LSB +: 2];
            end
        end
    end

    // Sequencer: single conversion or cyclic sweep over the slots
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            chan_reg <= 2'b00;
            slot_reg <= 4'h0;
            wait_cnt <= 6'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    wait_cnt <= 6'h00;
                    if (start_req && valid_sel && (!start_sweep || slot_total != 4'h0)) begin
                        state_reg <= ST_CONV;
                        slot_reg <= 4'h0;
                        chan_reg <= start_sweep ? 2'b00 : sel_reg[1:0];
                    end
                end
                ST_CONV: begin
                    wait_cnt <= wait_cnt + 6'h01;
                    if (conv_done || wait_cnt == `CHSEL_CONV_CYCLES)
                        state_reg <= ST_NEXT;
                end
                ST_NEXT: begin
                    wait_cnt <= 6'h00;
                    if (!sweep_reg || slot_reg + 4'h1 == slot_total) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        state_reg <= ST_CONV;
                        slot_reg <= slot_reg + 4'h1;
                        chan_reg <= ({2'b00, chan_reg} == sel_reg) ? 2'b00 : chan_reg + 2'b01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // One-hot source select; only four sources exist
    always_comb begin
        select_next = 4'h0;
        if (state_reg != ST_IDLE)
            select_next[chan_reg] = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            source_select <= 4'h0;
            slot_result <= 10'h000;
            slot_index <= 4'h0;
            slot_write <= 1'b0;
        end else begin
            source_select <= select_next;
            slot_write <= state_reg == ST_CONV && conv_done;
            if (state_reg == ST_CONV && conv_done) begin
                slot_result <= conv_result;
                slot_index <= slot_reg;
            end
        end
    end

    assign conv_start = state_reg == ST_CONV && wait_cnt == 6'h00;
    assign busy = state_reg != ST_IDLE;

    // Priority-conversion offset reads zero and ignores writes
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (bus_addr)
            `CHSEL_OFF_MODE_ZERO: rdata_next = {30'h0, busy, sweep_reg};
            `CHSEL_OFF_MODE_ONE: rdata_next = {26'h0, len_reg, sel_reg};
            `CHSEL_OFF_STATUS: rdata_next = {22'h0, slot_reg, chan_reg, 1'b0, busy, 2'b00};
            `CHSEL_OFF_PRIORITY: rdata_next = 32'h0000_0000;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            bus_rdata <= 32'h0000_0000;
        else if (bus_read)
            bus_rdata <= rdata_next;
        else
            bus_rdata <= 32'h0000_0000;
    end

    a_select_onehot: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot0(source_select)) else $error("source select not one-hot");
    a_fixed_channel: assert property (@(posedge clk) disable iff (sys_rst)
        (busy && !sweep_reg) |-> chan_reg == sel_reg[1:0]) else $error("fixed channel wrong");
    a_sweep_range: assert property (@(posedge clk) disable iff (sys_rst)
        (busy && sweep_reg) |-> {2'b00, chan_reg} <= sel_reg) else $error("sweep left range");
    a_sweep_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_NEXT && sweep_reg && {2'b00, chan_reg} == sel_reg && slot_reg + 4'h1 != slot_total)
        |=> chan_reg == 2'b00) else $error("sweep did not wrap");
    a_slot_bound: assert property (@(posedge clk) disable iff (sys_rst)
        busy |-> slot_reg < slot_total || !sweep_reg) else $error("slot past total");
    a_select_follow: assert property (@(posedge clk) disable iff (sys_rst)
        busy |=> source_select == (4'h1 << $past(chan_reg))) else $error("select lags channel");
    a_bad_sel_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_IDLE && !valid_sel) |=> state_reg == ST_IDLE) else $error("bad selector started");
    a_start_only_sw: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_IDLE && !start_req) |=> state_reg == ST_IDLE) else $error("start without write");

    // Sequencing and register checks
    a_idle_select_zero: assert property (@(posedge clk) disable iff (sys_rst)
        !busy |=> source_select == 4'h0) else $error("select active while idle");
    a_start_pulse_once: assert property (@(posedge clk) disable iff (sys_rst)
        conv_start |=> !conv_start) else $error("start pulse too long");
    a_slot_in_range: assert property (@(posedge clk) disable iff (sys_rst)
        (slot_write && sweep_reg) |-> slot_index < slot_total) else $error("slot index past total");
    a_fixed_one_slot: assert property (@(posedge clk) disable iff (sys_rst)
        (slot_write && !sweep_reg) |-> slot_index == 4'h0) else $error("fixed run used later slot");
    a_fixed_run_ends: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_NEXT && !sweep_reg) |=> state_reg == ST_IDLE) else $error("fixed run did not end");
    a_sweep_last_ends: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_NEXT && sweep_reg && slot_reg + 4'h1 == slot_total) |=> !busy) else $error("sweep overran");
    a_sweep_slot_step: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_NEXT && sweep_reg && slot_reg + 4'h1 != slot_total)
        |=> slot_reg == $past(slot_reg) + 4'h1) else $error("slot did not advance");
    a_sweep_chan_step: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_NEXT && sweep_reg && {2'b00, chan_reg} != sel_reg && slot_reg + 4'h1 != slot_total)
        |=> chan_reg == $past(chan_reg) + 2'b01) else $error("channel did not advance");
    a_conv_timeout: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_CONV && wait_cnt == `CHSEL_CONV_CYCLES) |=> state_reg == ST_NEXT) else $error("timeout missed");
    a_config_hold: assert property (@(posedge clk) disable iff (sys_rst)
        busy |=> $stable(sel_reg) && $stable(len_reg) && $stable(sweep_reg)) else $error("config changed while busy");
    a_sweep_from_zero: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(busy) && sweep_reg) |-> chan_reg == 2'b00) else $error("sweep did not start at zero");
    a_first_conv_start: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(busy) |-> conv_start) else $error("no start on first slot");
    a_reserved_len_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_IDLE && start_req && bus_wdata[`CHSEL_BIT_SWEEP] && len_reg == 2'b11)
        |=> state_reg == ST_IDLE) else $error("reserved length started");
    a_priority_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (bus_read && bus_addr == `CHSEL_OFF_PRIORITY) |=> bus_rdata == 32'h0000_0000) else $error("priority not zero");
    a_rdata_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !bus_read |=> bus_rdata == 32'h0000_0000) else $error("read data outside read cycle");
    a_mode_readback: assert property (@(posedge clk) disable iff (sys_rst)
        (bus_read && bus_addr == `CHSEL_OFF_MODE_ONE) |=> bus_rdata == {26'h0, $past(len_reg), $past(sel_reg)})
        else $error("mode word readback wrong");
    a_result_capture: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_CONV && conv_done) |=> slot_write && slot_result == $past(conv_result)) else $error("result lost");

    // Scenario covers
    c_fixed: cover property (@(posedge clk) disable iff (sys_rst) slot_write && !sweep_reg);
    c_sweep12: cover property (@(posedge clk) disable iff (sys_rst) slot_write && slot_index == 4'hb);
    c_wrap: cover property (@(posedge clk) disable iff (sys_rst) busy && sweep_reg && chan_reg == 2'b00 && slot_reg != 4'h0);
    c_timeout: cover property (@(posedge clk) disable iff (sys_rst) state_reg == ST_CONV && wait_cnt == `CHSEL_CONV_CYCLES);
    c_refused: cover property (@(posedge clk) disable iff (sys_rst) state_reg == ST_IDLE && start_req && !valid_sel);
endmodule // adc_channel_select

// ---- core/adc_chsel_defs.svh ----
// Constants for the converter channel selection block
`ifndef ADC_CHSEL_DEFS_SVH
`define ADC_CHSEL_DEFS_SVH
`define CHSEL_OFF_MODE_ZERO 4'h0
`define CHSEL_OFF_MODE_ONE 4'h4
`define CHSEL_OFF_STATUS 4'h8
`define CHSEL_OFF_PRIORITY 4'hc
`define CHSEL_BIT_SWEEP 0
`define CHSEL_BIT_START 1
`define CHSEL_SEL_LSB 0
`define CHSEL_LEN_LSB 4
`define CHSEL_LAST_CHANNEL 4'h3
`define CHSEL_SLOTS_LEN0 4'h4
`define CHSEL_SLOTS_LEN1 4'h8
`define CHSEL_SLOTS_LEN2 4'hc
`define CHSEL_CONV_CYCLES 6'h20
`endif

// ---- core/adc_chsel_pkg.sv ----
// Types for the converter channel selection block
package adc_chsel_pkg;
    typedef logic [3:0] reg_addr_t;
    typedef logic [31:0] reg_data_t;
    typedef logic [1:0] channel_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_NEXT = 3'b100
    } sweep_state_t;
endpackage

// ---- tb/conv_core_model.sv ----
// Behavioural model of the analog multiplexer and conversion core
`timescale 1ns/1ps
module conv_core_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic conv_start,
    input wire logic [3:0] source_select,
    input wire logic slow,
    output logic conv_done,
    output logic [9:0] conv_result
);
    logic [4:0] cnt_reg;
    logic run_reg;
    // Result carries the one-hot source seen, so the mapping shows in each slot
    always_ff @(posedge clk) begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (sys_rst) begin
            run_reg <= 1'b0;
            cnt_reg <= 5'h0;
            conv_result <= 10'h0;
        end else if (conv_start) begin
            run_reg <= 1'b1;
            cnt_reg <= slow ? 5'h14 : 5'h3;
        end else if (run_reg) begin
            cnt_reg <= cnt_reg - 5'h1;
            if (cnt_reg == 5'h1) begin
                run_reg <= 1'b0;
                conv_done <= 1'b1;
                conv_result <= {6'h2a, source_select};
            end
        end
    end
endmodule // conv_core_model

// ---- tb/test_adc_channel_select.sv ----
// Self-checking testbench for the converter channel selection block
`timescale 1ns/1ps
module test_adc_channel_select;
    import adc_chsel_pkg::*;
    logic clk = 0, sys_rst = 1, bus_write = 0, bus_read = 0, slow = 0;
    logic conv_done, conv_start, busy, slot_write;
    reg_addr_t bus_addr = '0;
    reg_data_t bus_wdata = '0, bus_rdata;
    logic [3:0] source_select, slot_index;
    logic [9:0] conv_result, slot_result;
    int num_errors = 0, checks = 0;
    always #10 clk = ~clk;
    adc_channel_select adc_channel_select_i (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
        .source_select(source_select), .conv_start(conv_start), .conv_done(conv_done),
        .conv_result(conv_result), .busy(busy), .slot_index(slot_index), .slot_result(slot_result),
        .slot_write(slot_write));
    conv_core_model conv_core_model_i (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start),
        .source_select(source_select), .slow(slow), .conv_done(conv_done), .conv_result(conv_result));
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input reg_addr_t a, input reg_data_t d);
        @(posedge clk);
        bus_addr <= a; bus_wdata <= d; bus_write <= 1'b1;
        @(posedge clk);
        bus_write <= 1'b0;
    endtask
    task rd(input reg_addr_t a, input reg_data_t exp);
        @(posedge clk);
        bus_addr <= a; bus_read <= 1'b1;
        @(posedge clk);
        bus_read <= 1'b0;
        #1 chk("read data", exp, bus_rdata);
    endtask
    // Starts a run and checks every stored slot against the expected channel
    task run(input logic sweep, input logic [3:0] sel, input logic [1:0] len, input int n);
        int k, w;
        wr(4'h4, {26'h0, len, sel});
        wr(4'h0, {30'h0, 1'b1, sweep});
        for (k = 0; k < n; k++) begin
            w = 0;
            do begin @(posedge clk); #1 w++; end while (slot_write !== 1'b1 && w < 100);
            chk("slot write", 1, slot_write);
            chk("slot index", k, slot_index);
            chk("slot result", {6'h2a, 4'h1 << (sweep ? k % (sel + 1) : sel)}, slot_result);
        end
        repeat (3) @(posedge clk);
        #1 chk("busy after run", 0, busy);
    endtask
    task fixed_channels;
        for (int c = 0; c < 4; c++) begin
            run(1'b0, c[3:0], 2'b00, 1);
        end
    endtask
    task sweep_lengths;
        slow = 1'b1;
        run(1'b1, 4'h1, 2'b00, 4);
        slow = 1'b0;
        run(1'b1, 4'h3, 2'b01, 8);
        run(1'b1, 4'h2, 2'b10, 12);
    endtask
    task refused_start;
        rd(4'h8, 32'h2e0);
        wr(4'h4, 32'h14);
        rd(4'h4, 32'h14);
        wr(4'h0, 32'h3);
        repeat (2) @(posedge clk);
        #1 chk("busy unsupported selector", 0, busy);
        wr(4'h4, 32'h31);
        wr(4'h0, 32'h3);
        repeat (2) @(posedge clk);
        #1 chk("busy reserved length", 0, busy);
        rd(4'h0, 32'h1);
    endtask
    task reset_mid_run;
        wr(4'h4, 32'h13);
        wr(4'h0, 32'h3);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk("busy after reset", 0, busy);
        chk("select after reset", 0, source_select);
        rd(4'h4, 32'h0);
    endtask
    task priority_place;
        rd(4'hc, 32'h0);
    endtask
    task results;
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        fixed_channels();
        sweep_lengths();
        refused_start();
        reset_mid_run();
        priority_place();
        results();
    end
    initial begin
        #100000;
        num_errors++;
        results();
    end
endmodule // test_adc_channel_select
